// file: rtl/hls_top.v
// HDLC link statistics counters with AHB-Lite register access
// Operation
// - Count every good received frame until software clears.
// - Add each good received frame's octet count to a total.
// - Report rx and tx frames seen in the last 60 seconds.
// - Report rx and tx octets seen in the last 60 seconds.
// - Count received frames with illegal length.
// - Count received frames whose bit count is not octet aligned.
// - Seven or more consecutive ones in a frame count one abort.
// - Count received frames with a bad check sequence.
// - Count received frames dropped for lack of buffer space.
// - Count every transmitted frame.
// - Add each sent frame's octet count to a total.
// - Count transmit frames dropped for lack of buffers.
// - Expose the current transmit queue depth in frames.
// - Keep the peak transmit queue depth reached since the last software clear.
// - Count frames discarded when the queue overflows.
// - Track current and peak depth per voice, data, management class.
// - Software clear zeroes all statistics counters.
// - Each subscriber port reports one of six call states.
// - Far tone state shown while far end supplies ring-back tone.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "hls_map.vh"
module hls_top #(
  parameter TICK_CYC = `HLS_TICK_CYC
) (
  input wire hclk, // Bus clock
  input wire hresetn, // Async reset, active low
  input wire ce, // Clock enable, freezes all state when low
  input wire hsel, // Slave select
  input wire [7:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write strobe
  input wire [2:0] hsize, // Transfer size
  input wire hready, // Bus ready in
  input wire [31:0] hwdata, // Write data
  output reg [31:0] hrdata, // Read data
  output reg hreadyout, // Ready out
  output reg hresp, // Response, always OKAY
  input wire rx_end, // Received frame ended, pulse
  input wire [15:0] rx_octets, // Octets of the ended frame
  input wire rx_bit_mis, // Bit count not a multiple of eight
  input wire rx_len_bad, // Length outside limits
  input wire rx_crc_bad, // Check sequence failed
  input wire rx_no_buf, // No buffer space for the frame
  input wire rx_bit, // Received line bit
  input wire rx_bit_vld, // Line bit valid
  input wire rx_in_frame, // Between opening and closing flags
  input wire tx_end, // Frame transmitted, pulse
  input wire [15:0] tx_octets, // Octets of the sent frame
  input wire tx_no_buf, // Transmit frame dropped, no buffers
  input wire tx_push, // Frame queued for transmission
  input wire tx_pop, // Frame taken from the queue
  input wire [1:0] tx_class, // Class of push/pop: 0 voice 1 data 2 mng
  input wire [`HLS_DEPTH_W-1:0] q_cap, // Queue capacity in frames
  input wire [2:0] port_state, // Call state from signalling
  input wire far_tone, // Far end supplies ring-back tone
  output reg [2:0] port_state_out, // Reported call state
  output reg [`HLS_DEPTH_W-1:0] q_depth // Current queue depth
);
  localparam DW = `HLS_DEPTH_W;
  localparam [31:0] TICK_LAST = TICK_CYC - 1;
  localparam [5:0] WIN_LAST = `HLS_WIN_S - 1;
  localparam [2:0] ABORT_LAST = `HLS_ONES_ABORT - 1;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  reg [1:0] ctrl_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  wire addr_ph = hsel & hready & htrans[1];
  wire clr = ce & wr_pend_r & (wr_addr_r == `HLS_CTRL) &
             hwdata[`HLS_CTRL_CLR_BIT];
  wire en = ctrl_r[`HLS_CTRL_EN_BIT];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      ctrl_r <= `HLS_CTRL_RESET;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_pend_r <= addr_ph & hwrite;
      wr_addr_r <= haddr;
      if (wr_pend_r && wr_addr_r == `HLS_CTRL) begin
        ctrl_r <= {hwdata[`HLS_CTRL_EN_BIT], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Totals and error counters
  // ****************************************************************
  reg [31:0] rx_frm_r, rx_oct_r, len_r, algn_r, abrt_r, crc_r, ovr_r;
  reg [31:0] tx_frm_r, tx_oct_r, und_r, freed_r;
  wire rx_good = rx_end & ~rx_len_bad & ~rx_bit_mis & ~rx_crc_bad &
                 ~rx_no_buf;
  reg [2:0] ones_r;
  reg ab_done_r;
  wire one_in = rx_in_frame & rx_bit_vld & rx_bit;
  wire ab_hit = one_in & (ones_r == ABORT_LAST) & ~ab_done_r;
  wire q_full = (q_depth >= q_cap);
  wire q_inc = tx_push & ~q_full;
  wire q_dec = tx_pop & (q_depth != {DW{1'b0}});
  wire drop = tx_push & q_full;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_frm_r <= 32'h0; rx_oct_r <= 32'h0; len_r <= 32'h0;
      algn_r <= 32'h0; abrt_r <= 32'h0; crc_r <= 32'h0; ovr_r <= 32'h0;
      tx_frm_r <= 32'h0; tx_oct_r <= 32'h0; und_r <= 32'h0;
      freed_r <= 32'h0; ones_r <= 3'h0; ab_done_r <= 1'b0;
    end else if (ce) begin
      if (!rx_in_frame) begin
        ones_r <= 3'h0;
        ab_done_r <= 1'b0;
      end else if (rx_bit_vld) begin
        if (!rx_bit) begin
          ones_r <= 3'h0;
          ab_done_r <= 1'b0;
        end else if (ones_r != ABORT_LAST) begin
          ones_r <= ones_r + 3'h1;
        end else begin
          ab_done_r <= 1'b1;
        end
      end
      if (clr) begin
        rx_frm_r <= 32'h0; rx_oct_r <= 32'h0; len_r <= 32'h0;
        algn_r <= 32'h0; abrt_r <= 32'h0; crc_r <= 32'h0;
        ovr_r <= 32'h0; tx_frm_r <= 32'h0; tx_oct_r <= 32'h0;
        und_r <= 32'h0; freed_r <= 32'h0;
      end else if (en) begin
        if (rx_good) begin
          rx_frm_r <= rx_frm_r + 32'h1;
          rx_oct_r <= rx_oct_r + {16'h0, rx_octets};
        end
        if (rx_end && rx_len_bad) len_r <= len_r + 32'h1;
        if (rx_end && rx_bit_mis) algn_r <= algn_r + 32'h1;
        if (ab_hit) abrt_r <= abrt_r + 32'h1;
        if (rx_end && rx_crc_bad) crc_r <= crc_r + 32'h1;
        if (rx_end && rx_no_buf) ovr_r <= ovr_r + 32'h1;
        if (tx_end) begin
          tx_frm_r <= tx_frm_r + 32'h1;
          tx_oct_r <= tx_oct_r + {16'h0, tx_octets};
        end
        if (tx_no_buf) und_r <= und_r + 32'h1;
        if (drop) freed_r <= freed_r + 32'h1;
      end
    end
  end

  // ****************************************************************
  // Sliding one-minute window
  // ****************************************************************
  // Sixty one-second buckets; the window sum adds the live bucket and
  // drops the oldest on each tick, so a reading spans the last minute.
  reg [31:0] tick_cnt_r;
  reg [5:0] slot_r;
  wire tick = (tick_cnt_r == TICK_LAST);
  reg [31:0] cur_r [0:3];
  reg [31:0] sum_r [0:3];
  wire [3:0] ev_on = {tx_end, tx_end, rx_good, rx_good};
  wire [31:0] ev_amt [0:3];
  assign ev_amt[0] = 32'h1;
  assign ev_amt[1] = {16'h0, rx_octets};
  assign ev_amt[2] = 32'h1;
  assign ev_amt[3] = {16'h0, tx_octets};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 32'h0;
      slot_r <= 6'h0;
    end else if (ce) begin
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
      if (tick) slot_r <= (slot_r == WIN_LAST) ? 6'h0 : slot_r + 6'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_win
      wire [31:0] add = (en && ev_on[g]) ? ev_amt[g] : 32'h0;
      // One history bank per lane keeps a single driver per array
      reg [31:0] hist [0:59];
      integer k;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cur_r[g] <= 32'h0;
          sum_r[g] <= 32'h0;
        end else if (ce) begin
          if (clr) begin
            cur_r[g] <= 32'h0;
            sum_r[g] <= 32'h0;
          end else if (tick) begin
            cur_r[g] <= add;
            sum_r[g] <= sum_r[g] + add - hist[slot_r];
          end else begin
            cur_r[g] <= cur_r[g] + add;
            sum_r[g] <= sum_r[g] + add;
          end
        end
      end
      // Reset clears history too, so the first minute never reads unknown
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          for (k = 0; k < 60; k = k + 1) hist[k] <= 32'h0;
        end else if (ce && clr) begin
          for (k = 0; k < 60; k = k + 1) hist[k] <= 32'h0;
        end else if (ce && tick) begin
          hist[slot_r] <= cur_r[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Queue depth, overall and per class
  // ****************************************************************
  reg [DW-1:0] q_max_r;
  reg [DW-1:0] cls_cur_r [0:2];
  reg [DW-1:0] cls_max_r [0:2];
  wire [DW-1:0] q_nxt = q_depth + {{DW-1{1'b0}}, q_inc} -
                        {{DW-1{1'b0}}, q_dec};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_depth <= {DW{1'b0}};
      q_max_r <= {DW{1'b0}};
    end else if (ce) begin
      q_depth <= q_nxt;
      if (clr) q_max_r <= q_nxt;
      else if (q_nxt > q_max_r) q_max_r <= q_nxt;
    end
  end

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_cls
      wire hit = (tx_class == g);
      wire inc = q_inc & hit;
      wire dec = tx_pop & hit & (cls_cur_r[g] != {DW{1'b0}});
      wire [DW-1:0] nxt = cls_cur_r[g] + {{DW-1{1'b0}}, inc} -
                          {{DW-1{1'b0}}, dec};
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cls_cur_r[g] <= {DW{1'b0}};
          cls_max_r[g] <= {DW{1'b0}};
        end else if (ce) begin
          cls_cur_r[g] <= nxt;
          if (clr) cls_max_r[g] <= nxt;
          else if (nxt > cls_max_r[g]) cls_max_r[g] <= nxt;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Call state
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_state_out <= `HLS_ST_IDLE_BOTH;
    end else if (ce) begin
      if (far_tone) begin
        port_state_out <= `HLS_ST_FAR_TONE;
      end else begin
        case (port_state)
          `HLS_ST_IDLE_BOTH, `HLS_ST_ACTIVE, `HLS_ST_LOCAL_IDLE,
          `HLS_ST_REMOTE_IDLE, `HLS_ST_RINGING:
            port_state_out <= port_state;
          default: port_state_out <= `HLS_ST_IDLE_BOTH;
        endcase
      end
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  reg [31:0] rd_nxt;
  always @* begin
    case (haddr)
      `HLS_CTRL: rd_nxt = {30'h0, ctrl_r};
      `HLS_RX_FRM: rd_nxt = rx_frm_r;
      `HLS_RX_OCT: rd_nxt = rx_oct_r;
      `HLS_RX_FRM60: rd_nxt = sum_r[0];
      `HLS_RX_OCT60: rd_nxt = sum_r[1];
      `HLS_LEN_ERR: rd_nxt = len_r;
      `HLS_ALIGN_ERR: rd_nxt = algn_r;
      `HLS_ABORT: rd_nxt = abrt_r;
      `HLS_CRC_ERR: rd_nxt = crc_r;
      `HLS_OVERRUN: rd_nxt = ovr_r;
      `HLS_TX_FRM: rd_nxt = tx_frm_r;
      `HLS_TX_OCT: rd_nxt = tx_oct_r;
      `HLS_TX_FRM60: rd_nxt = sum_r[2];
      `HLS_TX_OCT60: rd_nxt = sum_r[3];
      `HLS_UNDERRUN: rd_nxt = und_r;
      `HLS_FREED: rd_nxt = freed_r;
      `HLS_QDEPTH: rd_nxt = {16'h0, q_max_r, q_depth};
      `HLS_CLS_DEPTH: rd_nxt = {8'h0, cls_max_r[2], cls_max_r[1],
                                cls_max_r[0]};
      `HLS_PORT_STATE: rd_nxt = {cls_cur_r[2], cls_cur_r[1],
                                 cls_cur_r[0], 5'h0, port_state_out};
      default: rd_nxt = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ce && addr_ph && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end
endmodule

// file: rtl/hls_map.vh
// Register offsets, fields, reset values and timing counts for link statistics
`ifndef HLS_MAP_VH
`define HLS_MAP_VH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define HLS_CTRL 8'h00
`define HLS_RX_FRM 8'h04
`define HLS_RX_OCT 8'h08
`define HLS_RX_FRM60 8'h0c
`define HLS_RX_OCT60 8'h10
`define HLS_LEN_ERR 8'h14
`define HLS_ALIGN_ERR 8'h18
`define HLS_ABORT 8'h1c
`define HLS_CRC_ERR 8'h20
`define HLS_OVERRUN 8'h24
`define HLS_TX_FRM 8'h28
`define HLS_TX_OCT 8'h2c
`define HLS_TX_FRM60 8'h30
`define HLS_TX_OCT60 8'h34
`define HLS_UNDERRUN 8'h38
`define HLS_FREED 8'h3c
`define HLS_QDEPTH 8'h40
`define HLS_CLS_DEPTH 8'h44
`define HLS_PORT_STATE 8'h48
// ****************************************************************
// Fields
// ****************************************************************
`define HLS_CTRL_CLR_BIT 0
`define HLS_CTRL_EN_BIT 1
`define HLS_CTRL_RESET 2'h2
`define HLS_DEPTH_W 8
// ****************************************************************
// Call states
// ****************************************************************
`define HLS_ST_IDLE_BOTH 3'h0
`define HLS_ST_FAR_TONE 3'h1
`define HLS_ST_ACTIVE 3'h2
`define HLS_ST_LOCAL_IDLE 3'h3
`define HLS_ST_REMOTE_IDLE 3'h4
`define HLS_ST_RINGING 3'h5
// ****************************************************************
// Timing
// ****************************************************************
`define HLS_CLK_HZ 20000000
`define HLS_TICK_S 1
`define HLS_TICK_CYC (`HLS_CLK_HZ * `HLS_TICK_S)
`define HLS_WIN_S 60
`define HLS_ONES_ABORT 7
`endif

// file: testbench/hls_top_asserts.sv
// Port checker for the link statistics block
`timescale 1ns/1ps
`include "hls_map.vh"
module hls_top_asserts (
  input wire hclk, // Clock
  input wire hresetn, // Reset, active low
  input wire ce, // Clock enable
  input wire hsel, // Select
  input wire [7:0] haddr, // Address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write
  input wire hready, // Ready in
  input wire [31:0] hrdata, // Read data
  input wire hreadyout, // Ready out
  input wire hresp, // Response
  input wire tx_push, // Queue push
  input wire tx_pop, // Queue pop
  input wire [2:0] port_state, // State in
  input wire far_tone, // Far tone
  input wire [`HLS_DEPTH_W-1:0] q_cap, // Capacity
  input wire [2:0] port_state_out, // State out
  input wire [`HLS_DEPTH_W-1:0] q_depth // Depth
);
  // ********
  // Checks
  // ********
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_addr;
    ce && hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence full_push;
    ce && tx_push && !tx_pop && q_depth >= q_cap;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  unmapped_zero_a: assert property (
    rd_addr ##0 (haddr >= 8'h4c) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  freeze_hold_a: assert property (
    !ce |=> $stable(q_depth) && $stable(port_state_out))
    else $error("state moved with enable low");
  far_tone_a: assert property (
    ce && far_tone |=> port_state_out == 3'h1)
    else $error("far tone not reported");
  state_map_a: assert property (ce && !far_tone |=>
    port_state_out == (($past(port_state) > 3'h5 ||
    $past(port_state) == 3'h1) ? 3'h0 : $past(port_state)))
    else $error("call state wrong");
  push_full_a: assert property (
    full_push |=> q_depth == $past(q_depth))
    else $error("full queue grew");
  push_grow_a: assert property (
    ce && tx_push && !tx_pop && q_depth < q_cap |=>
    q_depth == $past(q_depth) + 8'h1)
    else $error("push did not grow depth");
  pop_drop_a: assert property (
    ce && tx_pop && !tx_push && q_depth != 8'h0 |=>
    q_depth == $past(q_depth) - 8'h1)
    else $error("pop did not shrink depth");
endmodule
bind hls_top hls_top_asserts chk (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tx_push(tx_push), .tx_pop(tx_pop), .port_state(port_state),
  .far_tone(far_tone), .q_cap(q_cap), .port_state_out(port_state_out),
  .q_depth(q_depth));

// file: testbench/hls_line_peer.sv
// Far framer model that drives the received line bit stream
`timescale 1ns/1ps
module hls_line_peer (
  input wire hclk, // Clock
  output wire rx_bit, // Line bit
  output reg rx_bit_vld, // Bit valid
  output reg rx_in_frame // Inside a frame
);
  reg fbit = 1'h0;
  reg tog = 1'h0;
  integer i;
  initial begin
    rx_bit_vld = 1'h0;
    rx_in_frame = 1'h0;
  end
  // Idle line toggles so no stale level can pass for a real bit
  always @(posedge hclk) begin
    tog <= ~tog;
  end
  assign rx_bit = rx_in_frame ? fbit : tog;
  // Run of ones inside one frame; slow leaves a gap after each bit
  task send(input integer ones, input slow);
    begin
      @(posedge hclk) rx_in_frame <= 1'h1;
      rx_bit_vld <= 1'h1;
      for (i = 0; i < ones; i = i + 1) begin
        @(posedge hclk) fbit <= 1'h1;
        rx_bit_vld <= 1'h1;
        if (slow) begin
          @(posedge hclk) rx_bit_vld <= 1'h0;
        end
      end
      @(posedge hclk) fbit <= 1'h0;
      rx_bit_vld <= 1'h1;
      @(posedge hclk) rx_in_frame <= 1'h0;
      rx_bit_vld <= 1'h0;
    end
  endtask
endmodule

// file: testbench/hls_link_statistics_bench.sv
// Self-checking bench for the link statistics block
`timescale 1ns/1ps
`include "hls_map.vh"
module hls_link_statistics_bench;
  localparam TK = 20;
  reg hclk = 1'h0, hresetn = 1'h0, ce = 1'h1, hwrite = 1'h0;
  reg rx_end = 1'h0, rx_bit_mis = 1'h0, rx_len_bad = 1'h0;
  reg rx_crc_bad = 1'h0, rx_no_buf = 1'h0, tx_end = 1'h0;
  reg tx_no_buf = 1'h0, tx_push = 1'h0, tx_pop = 1'h0, far_tone = 1'h0;
  reg [7:0] haddr = 8'h0;
  reg [1:0] htrans = 2'h0, tx_class = 2'h0;
  reg [31:0] hwdata = 32'h0, q;
  reg [15:0] rx_octets = 16'h0, tx_octets = 16'h0;
  reg [2:0] port_state = 3'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rx_bit, rx_bit_vld, rx_in_frame;
  wire [2:0] port_state_out;
  wire [7:0] q_depth;
  integer mismatches = 0, compares = 0, i;
  always #25 hclk = ~hclk;
  hls_top #(.TICK_CYC(TK)) uut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_end(rx_end),
    .rx_octets(rx_octets), .rx_bit_mis(rx_bit_mis), .rx_len_bad(rx_len_bad),
    .rx_crc_bad(rx_crc_bad), .rx_no_buf(rx_no_buf), .rx_bit(rx_bit),
    .rx_bit_vld(rx_bit_vld), .rx_in_frame(rx_in_frame), .tx_end(tx_end),
    .tx_octets(tx_octets), .tx_no_buf(tx_no_buf), .tx_push(tx_push),
    .tx_pop(tx_pop), .tx_class(tx_class), .q_cap(8'h03),
    .port_state(port_state), .far_tone(far_tone),
    .port_state_out(port_state_out), .q_depth(q_depth));
  hls_line_peer peer (.hclk(hclk), .rx_bit(rx_bit),
    .rx_bit_vld(rx_bit_vld), .rx_in_frame(rx_in_frame));
  // ********
  // Tasks
  // ********
  task wrap_up;
    begin
      $display("Counts: %0d mismatches, %0d compares", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk) htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'h0, a, 32'h0);
      cmp(q, e);
    end
  endtask
  // Flags are length, alignment, check sequence, no buffer
  task rxf(input [15:0] n, input [3:0] f);
    begin
      @(posedge hclk) rx_end <= 1'h1;
      rx_octets <= n;
      {rx_len_bad, rx_bit_mis, rx_crc_bad, rx_no_buf} <= f;
      @(posedge hclk) rx_end <= 1'h0;
      {rx_len_bad, rx_bit_mis, rx_crc_bad, rx_no_buf} <= 4'h0;
    end
  endtask
  task txf(input [15:0] n, input nb);
    begin
      @(posedge hclk) tx_end <= ~nb;
      tx_no_buf <= nb;
      tx_octets <= n;
      @(posedge hclk) tx_end <= 1'h0;
      tx_no_buf <= 1'h0;
    end
  endtask
  task qop(input ps, input pp, input [1:0] c);
    begin
      @(posedge hclk) tx_push <= ps;
      tx_pop <= pp;
      tx_class <= c;
      @(posedge hclk) tx_push <= 1'h0;
      tx_pop <= 1'h0;
    end
  endtask
  // ********
  // Scenarios
  // ********
  task t_rx;
    begin
      rd(`HLS_RX_FRM, 32'h0);
      rd(8'h4c, 32'h0);
      rxf(16'h0a, 4'h0);
      rxf(16'h14, 4'h0);
      rxf(16'h1e, 4'h0);
      for (i = 0; i < 4; i = i + 1) rxf(16'h28, 4'h1 << i);
      @(posedge hclk) ce <= 1'h0;
      rxf(16'h50, 4'h0);
      @(posedge hclk) ce <= 1'h1;
      rd(`HLS_RX_FRM, 32'h3);
      rd(`HLS_RX_OCT, 32'h3c);
      rd(`HLS_LEN_ERR, 32'h1);
      rd(`HLS_ALIGN_ERR, 32'h1);
      rd(`HLS_CRC_ERR, 32'h1);
      rd(`HLS_OVERRUN, 32'h1);
      rd(`HLS_RX_FRM60, 32'h3);
      rd(`HLS_RX_OCT60, 32'h3c);
    end
  endtask
  task t_tx;
    begin
      txf(16'h5, 1'h0);
      txf(16'h7, 1'h0);
      txf(16'h9, 1'h1);
      rd(`HLS_TX_FRM, 32'h2);
      rd(`HLS_TX_OCT, 32'hc);
      rd(`HLS_UNDERRUN, 32'h1);
      rd(`HLS_TX_FRM60, 32'h2);
      rd(`HLS_TX_OCT60, 32'hc);
    end
  endtask
  task t_abort;
    begin
      peer.send(8, 1'h1);
      peer.send(6, 1'h0);
      peer.send(7, 1'h0);
      rd(`HLS_ABORT, 32'h2);
    end
  endtask
  task t_queue;
    begin
      for (i = 0; i < 4; i = i + 1) qop(1'h1, 1'h0, 2'h0);
      @(negedge hclk) cmp({24'h0, q_depth}, 32'h3);
      rd(`HLS_FREED, 32'h1);
      qop(1'h0, 1'h1, 2'h0);
      bus(1'h0, `HLS_QDEPTH, 32'h0);
      cmp(q & 32'hffff, 32'h0302);
      qop(1'h1, 1'h0, 2'h1);
      bus(1'h0, `HLS_CLS_DEPTH, 32'h0);
      cmp(q & 32'hffffff, 32'h000103);
    end
  endtask
  task t_window;
    begin
      repeat (30 * TK) @(posedge hclk);
      rd(`HLS_RX_FRM60, 32'h3);
      repeat (32 * TK + 4) @(posedge hclk);
      rd(`HLS_RX_FRM60, 32'h0);
      rd(`HLS_TX_OCT60, 32'h0);
      rd(`HLS_RX_FRM, 32'h3);
    end
  endtask
  task t_state;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge hclk) port_state <= i[3:1];
        far_tone <= i[0];
        repeat (2) @(posedge hclk);
        cmp({29'h0, port_state_out}, i[0] ? 32'h1 :
          ((i[3:1] > 5 || i[3:1] == 1) ? 32'h0 : i[3:1]));
      end
    end
  endtask
  task t_clear;
    begin
      bus(1'h1, `HLS_CTRL, 32'h3);
      rd(`HLS_RX_FRM, 32'h0);
      rd(`HLS_ABORT, 32'h0);
      rd(`HLS_UNDERRUN, 32'h0);
      rd(`HLS_CTRL, 32'h2);
    end
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    rd(`HLS_CTRL, 32'h2);
    t_rx;
    t_tx;
    t_abort;
    t_queue;
    t_state;
    t_window;
    t_clear;
    wrap_up;
  end
  initial begin
    #400000;
    mismatches = mismatches + 1;
    wrap_up;
  end
endmodule
